//--- src/rrv_pkg.sv
// Constants and types for reference input re-validation.
// Assumes a single 100 MHz clock domain and synchronous event inputs.
package rrv_pkg;
  localparam int RRV_NUM_REFS = 2;
  localparam int RRV_CNT_W = 7;
  // Re-validation setting after reset, and its four divided-period counts
  localparam logic [1:0] RRV_SEL_RESET = 2'h0;
  localparam logic [6:0] RRV_COUNT_SEL0 = 7'h02;
  localparam logic [6:0] RRV_COUNT_SEL1 = 7'h10;
  localparam logic [6:0] RRV_COUNT_SEL2 = 7'h20;
  localparam logic [6:0] RRV_COUNT_SEL3 = 7'h40;
  localparam logic [6:0] RRV_COUNT_IDLE = 7'h00;
  localparam logic [6:0] RRV_COUNT_LAST = 7'h01;
  // Selection modes: bit 0 set means automatic selection
  localparam logic [1:0] RRV_MODE_MANUAL = 2'h0;
  localparam int RRV_MODE_AUTO_BIT = 0;
  localparam logic RRV_SELECT_RESET = 1'b0;

  // Per-input events from the activity monitor, one-cycle pulses
  typedef struct packed {
    logic loss_event;   // Loss of signal detected
    logic period_ok;    // One valid divided period seen
    logic period_miss;  // Edges missing for one divided period
  } rrv_ref_evt_t;

  typedef enum logic {RRV_GOOD, RRV_LOST} rrv_ref_state_t;

  // Divided-period count for a re-validation setting
  function automatic logic [6:0] rrv_count_of(input logic [1:0] sel);
    case (sel)
      2'h0: rrv_count_of = RRV_COUNT_SEL0;
      2'h1: rrv_count_of = RRV_COUNT_SEL1;
      2'h2: rrv_count_of = RRV_COUNT_SEL2;
      default: rrv_count_of = RRV_COUNT_SEL3;
    endcase
  endfunction : rrv_count_of
endpackage : rrv_pkg

//--- src/rrv_revalidation.sv
// Re-validation counters and loss flags for two reference inputs, plus
// the reference choice made from those flags.
// Assumes monitor events arrive as single-cycle pulses on clk, already
// taken after the input pre-divider.
// Limitation: the holdover bit of the selection mode is not modelled, so
// the holdover modes behave as their plain manual or automatic forms.
// Counts are in divided periods; the raw-input figure is the setting
// times the pre-divide ratio, which lives outside this block.
//
// How it works
// RQ1 - A loss event loads that input's counter with the programmed count.
// RQ2 - Each valid consecutive divided period decrements the counter by one.
// RQ3 - Missing edges for one period during counting reload the full count.
// RQ4 - Counter reaching zero declares the input good and clears its flag.
// RQ5 - Setting codes 0..3 select 2, 16, 32 or 64 divided periods.
// RQ6 - Each of the two inputs has its own counter and loss flag.
// RQ7 - Automatic modes choose the reference from loss flags and priority.
// RQ8 - Counter idles while flag clear; a new loss restarts the count.
`timescale 1ns/1ps
`default_nettype none
module rrv_revalidation
  import rrv_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] revalid_count_sel,
  input wire logic [1:0] ref_select_mode,
  input wire logic manual_ref_sel,
  input wire logic preferred_ref,
  input wire rrv_pkg::rrv_ref_evt_t [1:0] ref_evt,
  output logic [1:0] input_loss_flag,
  output logic [1:0] revalidated,
  output logic [13:0] revalid_count,
  output logic selected_ref
);
  import rrv_pkg::*;

  rrv_ref_state_t [1:0] state_ff;
  logic [1:0][6:0] count_ff;
  logic [1:0] done_ff;
  logic select_ff;
  logic nxt_select;
  logic [6:0] load_value;

  assign load_value = rrv_count_of(revalid_count_sel); // RQ5

  // Independent counter and flag per input. The count only matters while
  // the flag is set; forcing it to zero when good keeps the status word
  // clean for software and makes a fresh loss always start from the top.
  always_ff @(posedge clk) begin
    for (int i = 0; i < RRV_NUM_REFS; i++) begin // RQ6
      if (!rst_n) begin
        state_ff[i] <= RRV_GOOD;
        count_ff[i] <= RRV_COUNT_IDLE;
      end else if (ref_evt[i].loss_event) begin
        // Loss wins over a same-cycle good period; restart from the top
        state_ff[i] <= RRV_LOST; // RQ1
        count_ff[i] <= load_value; // RQ8
      end else begin
        case (state_ff[i])
          RRV_GOOD: begin
            count_ff[i] <= RRV_COUNT_IDLE; // RQ8
          end
          RRV_LOST: begin
            if (ref_evt[i].period_miss) begin
              count_ff[i] <= load_value; // RQ3
            end else if (ref_evt[i].period_ok) begin
              if (count_ff[i] == RRV_COUNT_LAST) begin
                count_ff[i] <= RRV_COUNT_IDLE; // RQ4
                state_ff[i] <= RRV_GOOD; // RQ4
              end else begin
                count_ff[i] <= count_ff[i] - RRV_COUNT_LAST; // RQ2
              end
            end
          end
          default: begin
            state_ff[i] <= RRV_GOOD;
          end
        endcase
      end
    end
  end

  // One-cycle notice that an input has just been re-validated
  // Registered so that it lines up with the flag drop seen outside
  always_ff @(posedge clk) begin
    for (int i = 0; i < RRV_NUM_REFS; i++) begin
      if (!rst_n) begin
        done_ff[i] <= 1'b0;
      end else begin
        done_ff[i] <= (state_ff[i] == RRV_LOST) && !ref_evt[i].loss_event &&
                      !ref_evt[i].period_miss && ref_evt[i].period_ok &&
                      (count_ff[i] == RRV_COUNT_LAST); // RQ4
      end
    end
  end

  // Reference choice; automatic modes hold the current input when both are lost, since
  // switching between two bad inputs only adds phase disturbance.
  always_comb begin
    nxt_select = select_ff;
    if (!ref_select_mode[RRV_MODE_AUTO_BIT]) begin
      nxt_select = manual_ref_sel;
    end else if (state_ff[preferred_ref] == RRV_GOOD) begin
      nxt_select = preferred_ref; // RQ7
    end else if (state_ff[!preferred_ref] == RRV_GOOD) begin
      nxt_select = !preferred_ref; // RQ7
    end
  end

  // Registered choice, so the reference mux never sees decode glitches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      select_ff <= RRV_SELECT_RESET;
    end else begin
      select_ff <= nxt_select;
    end
  end

  // Outputs straight from flops
  // The flag is a plain decode of one state flop, so it cannot glitch
  always_comb begin
    for (int i = 0; i < RRV_NUM_REFS; i++) begin
      input_loss_flag[i] = (state_ff[i] == RRV_LOST);
    end
  end
  assign revalidated = done_ff;
  assign revalid_count = {count_ff[1], count_ff[0]};
  assign selected_ref = select_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < RRV_NUM_REFS; g++) begin : g_chk
    // Loads and reloads take the setting of the cycle the event came in
    a_loss_loads_count: assert property ( // RQ1
      ref_evt[g].loss_event |=> input_loss_flag[g] &&
        count_ff[g] == rrv_count_of($past(revalid_count_sel)))
      else $error("loss event did not load the count");
    a_flag_rise_on_loss: assert property ( // RQ1
      $rose(input_loss_flag[g]) |-> $past(ref_evt[g].loss_event))
      else $error("loss flag rose without a loss event");
    a_miss_reloads: assert property ( // RQ3
      input_loss_flag[g] && !ref_evt[g].loss_event && ref_evt[g].period_miss
      |=> input_loss_flag[g] &&
        count_ff[g] == rrv_count_of($past(revalid_count_sel)))
      else $error("missing period did not reload the count");

    // Counting: one step per valid period, none otherwise
    a_period_decrements: assert property ( // RQ2
      input_loss_flag[g] && !ref_evt[g].loss_event &&
      !ref_evt[g].period_miss && ref_evt[g].period_ok && count_ff[g] > 7'h01
      |=> count_ff[g] == $past(count_ff[g]) - 7'h01 && input_loss_flag[g])
      else $error("valid period did not step the count by one");
    a_hold_no_period: assert property ( // RQ2
      input_loss_flag[g] && !ref_evt[g].loss_event &&
      !ref_evt[g].period_miss && !ref_evt[g].period_ok
      |=> $stable(count_ff[g]) && input_loss_flag[g])
      else $error("count moved without a period");
    a_quiet_input_holds: assert property ( // RQ6
      !ref_evt[g].loss_event && !ref_evt[g].period_miss &&
      !ref_evt[g].period_ok
      |=> $stable(count_ff[g]) && $stable(input_loss_flag[g]))
      else $error("input state moved without its own events");

    // Re-validation: the flag drops only at zero, with a one-cycle notice
    a_zero_clears_flag: assert property ( // RQ4
      $fell(input_loss_flag[g]) |-> $past(count_ff[g]) == 7'h01 &&
        count_ff[g] == 7'h00 && revalidated[g])
      else $error("flag cleared without the count reaching zero");
    a_lost_count_live: assert property ( // RQ4
      input_loss_flag[g] |-> count_ff[g] != RRV_COUNT_IDLE)
      else $error("count reached zero with the flag still set");
    a_pulse_marks_drop: assert property ( // RQ4
      revalidated[g] |-> !input_loss_flag[g] && $past(input_loss_flag[g]))
      else $error("re-validation notice without a flag drop");
    a_revalid_pulse_once: assert property ( // RQ4
      revalidated[g] |=> !revalidated[g])
      else $error("re-validation notice longer than one cycle");

    // A good input sits idle and ignores period events
    a_idle_count_zero: assert property ( // RQ8
      !input_loss_flag[g] |-> count_ff[g] == RRV_COUNT_IDLE)
      else $error("counter active while input good");
    a_good_stays_idle: assert property ( // RQ8
      !input_loss_flag[g] && !ref_evt[g].loss_event
      |=> !input_loss_flag[g] && count_ff[g] == RRV_COUNT_IDLE)
      else $error("good input left idle without a loss event");
    a_count_in_range: assert property ( // RQ5
      count_ff[g] <= 7'h40)
      else $error("count beyond largest setting");

    // Main scenarios per input
    c_revalidated: cover property (revalidated[g]);
    c_reload: cover property (
      input_loss_flag[g] && ref_evt[g].period_miss ##1 input_loss_flag[g]);
    c_loss_restart: cover property (
      input_loss_flag[g] && ref_evt[g].loss_event);
  end

  // Automatic modes: preferred if good, else the other, else hold
  a_auto_preferred: assert property ( // RQ7
    ref_select_mode[0] && !input_loss_flag[preferred_ref]
    |=> selected_ref == $past(preferred_ref))
    else $error("automatic mode skipped a good preferred input");
  a_auto_fallback: assert property ( // RQ7
    ref_select_mode[0] && input_loss_flag[preferred_ref] &&
    !input_loss_flag[!preferred_ref]
    |=> selected_ref != $past(preferred_ref))
    else $error("automatic mode kept a lost preferred input");
  a_auto_hold_both: assert property ( // RQ7
    ref_select_mode[0] && (&input_loss_flag) |=> $stable(selected_ref))
    else $error("choice moved with both inputs lost");

  // Manual modes follow the manual choice one cycle later
  a_manual_follows: assert property ( // RQ7
    !ref_select_mode[0] |=> selected_ref == $past(manual_ref_sel))
    else $error("manual mode ignored the manual choice");
  c_auto_switch: cover property (
    ref_select_mode[0] && input_loss_flag[preferred_ref] ##1
    selected_ref != preferred_ref);
  c_both_lost: cover property (
    ref_select_mode[0] && (&input_loss_flag));
endmodule : rrv_revalidation
`default_nettype wire

//--- testbench/rrv_src_model.sv
// Reference source model: divided periods, loss and missing-edge events.
// Assumes the bench moves its controls just after rising edges of clk.
`timescale 1ns/1ps
`default_nettype none
module rrv_src_model
  import rrv_pkg::*;
(
  input wire logic [1:0] run,
  input wire logic [1:0] loss,
  input wire logic [1:0] miss,
  output rrv_pkg::rrv_ref_evt_t [1:0] ref_evt
);
  // A lost or missing period never also shows as a valid one
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ref_evt[i] = {loss[i], run[i] & ~loss[i] & ~miss[i], miss[i]};
    end
  end
endmodule : rrv_src_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for reference re-validation and selection.
// Assumes the source model stands in for both reference inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rrv_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [1:0] mode = 2'h0;
  logic man = 1'b0;
  logic pref = 1'b0;
  logic [1:0] run = 2'h0;
  logic [1:0] loss = 2'h0;
  logic [1:0] miss = 2'h0;
  rrv_ref_evt_t [1:0] evt;
  logic [1:0] flag;
  logic [1:0] rv;
  logic [13:0] cnt;
  logic sref;
  int mismatches = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  rrv_src_model i_rrv_src_model (.run(run), .loss(loss), .miss(miss),
    .ref_evt(evt));
  rrv_revalidation i_rrv_revalidation (.clk(clk), .rst_n(rst_n),
    .revalid_count_sel(sel), .ref_select_mode(mode), .manual_ref_sel(man),
    .preferred_ref(pref), .ref_evt(evt), .input_loss_flag(flag),
    .revalidated(rv), .revalid_count(cnt), .selected_ref(sref));
  // Case equality so an unknown never passes
  task automatic chk(input string what, input logic [13:0] exp,
                     input logic [13:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Every setting, input 0: load, count down, clear at zero
  task automatic t_walk();
    logic [6:0] n [4] = '{7'h02, 7'h10, 7'h20, 7'h40};
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      sel <= s[1:0];
      loss <= 2'h1;
      @(posedge clk);
      loss <= 2'h0;
      run <= 2'h1;
      #1 chk("count0 load", {7'h00, n[s]}, cnt);
      chk("flag set", 14'h0001, {12'h000, flag});
      repeat (n[s] - 1) @(posedge clk);
      #1 chk("count0 last", 14'h0001, cnt);
      @(posedge clk);
      run <= 2'h0;
      #1 chk("flag clear", 14'h0000, {12'h000, flag});
      chk("revalidated", 14'h0001, {12'h000, rv});
    end
    $display("t_walk done");
  endtask : t_walk
  // Input 1: miss reloads, fresh loss restarts, input 0 stays idle
  task automatic t_miss();
    @(posedge clk);
    sel <= 2'h1;
    loss <= 2'h2;
    @(posedge clk);
    loss <= 2'h0;
    run <= 2'h2;
    repeat (5) @(posedge clk);
    miss <= 2'h2;
    @(posedge clk);
    miss <= 2'h0;
    #1 chk("count1 reload", {7'h10, 7'h00}, cnt);
    repeat (3) @(posedge clk);
    loss <= 2'h2;
    @(posedge clk);
    loss <= 2'h0;
    #1 chk("count1 restart", {7'h10, 7'h00}, cnt);
    repeat (16) @(posedge clk);
    run <= 2'h0;
    #1 chk("flag1 clear", 14'h0000, {12'h000, flag});
    chk("revalidated1", 14'h0002, {12'h000, rv});
    $display("t_miss done");
  endtask : t_miss
  // Manual choice, then automatic fallback on a lost preferred input
  task automatic t_select();
    @(posedge clk);
    man <= 1'b1;
    @(posedge clk);
    mode <= 2'h1;
    #1 chk("manual", 14'h0001, {13'h0000, sref});
    @(posedge clk);
    loss <= 2'h1;
    #1 chk("auto pref", 14'h0000, {13'h0000, sref});
    @(posedge clk);
    loss <= 2'h0;
    repeat (2) @(posedge clk);
    #1 chk("auto other", 14'h0001, {13'h0000, sref});
    $display("t_select done");
  endtask : t_select
  // Both lost: automatic mode holds; then preferred returns; mode 2 manual
  task automatic t_hold();
    pref <= 1'b1;
    loss <= 2'h2;
    @(posedge clk);
    loss <= 2'h0;
    @(posedge clk);
    pref <= 1'b0;
    @(posedge clk);
    #1 chk("auto hold", 14'h0001, {13'h0000, sref});
    sel <= 2'h0;
    loss <= 2'h1;
    @(posedge clk);
    loss <= 2'h0;
    run <= 2'h1;
    repeat (2) @(posedge clk);
    run <= 2'h0;
    @(posedge clk);
    #1 chk("auto back pref", 14'h0000, {13'h0000, sref});
    mode <= 2'h2;
    @(posedge clk);
    #1 chk("manual mode two", 14'h0001, {13'h0000, sref});
    $display("t_hold done");
  endtask : t_hold
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_walk();
    t_miss();
    t_select();
    t_hold();
    complete_run();
  end
  // Whole run needs well under 400 cycles
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
